// file: verilog/dct_params.svh
`ifndef DCT_PARAMS_SVH
`define DCT_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DCT_SETUP_ADDR   7'h06     // Offset of periodic_timer_setup
`define DCT_SETUP_RESET  16'h0000  // Value after every kind of reset
`define DCT_SETUP_RWMASK 16'heff7  // Bits 12 and 3 are read-only zero

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCT_T2_ON_LSB  13
`define DCT_T2_PER_LSB 9
`define DCT_WAKE_LSB   7
`define DCT_T1_ON_LSB  4
`define DCT_T1_PER_LSB 0

// ----------------------------------------------------------------
// Timing, on-time and period counts in 1 us ticks
// ----------------------------------------------------------------
`define DCT_CLK_NS  1000 / 125     // System clock period in ns (125 MHz)
`define DCT_TICK_NS 1000           // Timer tick in ns (1 us)
`define DCT_TICK_CYC ((`DCT_TICK_NS) / (`DCT_CLK_NS))
`define DCT_FILT_US  21'h00010     // Wake filter window, 16 us
`define DCT_ON_C1_US 21'h00064     // 0.1 ms
`define DCT_ON_C2_US 21'h0012c     // 0.3 ms
`define DCT_ON_C3_US 21'h003e8     // 1 ms
`define DCT_ON_C4_US 21'h02710     // 10 ms
`define DCT_ON_C5_US 21'h04e20     // 20 ms
`define DCT_PER_C0_US 21'h02710    // 10 ms
`define DCT_PER_C1_US 21'h04e20    // 20 ms
`define DCT_PER_C2_US 21'h0c350    // 50 ms
`define DCT_PER_C3_US 21'h186a0    // 100 ms
`define DCT_PER_C4_US 21'h30d40    // 200 ms
`define DCT_PER_C5_US 21'h7a120    // 500 ms
`define DCT_PER_C6_US 21'hf4240    // 1 s
`define DCT_PER_C7_US 21'h1e8480   // 2 s

`endif

// file: verilog/dct_pkg.sv
package dct_pkg;
    // Cyclic wake source selection
    typedef enum logic [1:0] {
        DCT_WAKE_OFF,
        DCT_WAKE_T1,
        DCT_WAKE_T2,
        DCT_WAKE_RSVD
    } dct_wake_t;
    // Wake filter selection codes, two of which name a timer
    typedef enum logic [2:0] {
        DCT_FILT_16US,
        DCT_FILT_64US,
        DCT_FILT_TIMER1,
        DCT_FILT_TIMER2,
        DCT_FILT_SYNC
    } dct_filt_t;
    // Tick count width, holds 2 s in microseconds
    typedef logic [20:0] dct_ticks_t;
endpackage

// file: verilog/dct_cyc_timer.sv
`timescale 1ns/10ps
`include "dct_params.svh"

// One periodic on-time generator, counting in 1 us ticks
module dct_cyc_timer
    import dct_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       tick,       // One-cycle 1 us enable
    input  wire logic       run,        // Timer running
    input  wire logic       hold_high,  // Stopped level when not running
    input  wire logic       restart,    // Start a fresh period
    input  wire dct_ticks_t on_ticks,
    input  wire dct_ticks_t per_ticks,
    output logic            drive,      // Switch drive level
    output logic            filt_win,   // Last 16 us of on-time
    output logic            on_end      // Pulse at end of on-time
);
    dct_ticks_t cnt_reg;                // Position inside the period

    // ----------------------------------------------------------------
    // Period counter
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst || !run || restart) begin
            cnt_reg <= '0;
        end else if (tick) begin
            // Wrap at the period end to start the next on-time
            if (cnt_reg >= per_ticks - 21'h000001) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 21'h000001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all registered
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drive    <= 1'b0;
            filt_win <= 1'b0;
            on_end   <= 1'b0;
        end else if (!run) begin
            drive    <= hold_high;   // R02
            filt_win <= 1'b0;
            on_end   <= 1'b0;
        end else begin
            drive    <= cnt_reg < on_ticks;  // R14
            // Window ends with the on-time; short on-times are all window
            filt_win <= (cnt_reg < on_ticks) &&
                        (cnt_reg + `DCT_FILT_US >= on_ticks);  // R13
            on_end   <= tick && (cnt_reg == on_ticks - 21'h000001);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_on_phase;
        (run && !restart && cnt_reg < on_ticks)[*2] |-> drive;
    endproperty
    a_on_phase: assert property (p_on_phase)  // R14
        else $error("Drive low inside on-time");

    property p_off_phase;
        (run && cnt_reg >= on_ticks)[*2] |-> !drive;
    endproperty
    a_off_phase: assert property (p_off_phase)  // R14
        else $error("Drive high after on-time");
endmodule

// file: verilog/dct_timer_ctrl.sv
`timescale 1ns/10ps
`include "dct_params.svh"

// What this block does
// R01: Timer 2 on-time codes one to five
// R02: Code 000 holds low, 110/111 hold high
// R03: Timer 2 period codes 10 ms to 2 s
// R04: Timer 1 on-time uses same encoding
// R05: Timer 1 period uses same encoding
// R06: Cyclic wake selects none, timer 1, 2
// R07: Bits 12 and 3 read zero
// R08: Every reset clears whole register
// R09: Timer runs once assigned and coded
// R10: Restart switch clear wipes that timer's settings
// R11: Other failures leave settings untouched
// R12: Sensing and wake share one timer
// R13: Filter 16 us at on-time end
// R14: On-time at period start, off otherwise
// R15: Reads show hardware-cleared values
module dct_timer_ctrl
    import dct_pkg::*;
#(
    parameter int TICK_CYC = `DCT_TICK_CYC  // Clock cycles per 1 us tick
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [6:0]  reg_addr,               // Register address
    input  wire logic        reg_wr,                 // Write strobe
    input  wire logic        reg_rd,                 // Read strobe
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        soft_reset_req,         // Soft reset pulse
    input  wire logic        restart_clear,          // Restart entry pulse
    input  wire logic [1:0]  sense_clear,            // Switch cleared in restart
    input  wire logic [1:0]  timer_assigned,         // Timer owns a switch
    input  wire logic [2:0]  wake_filter_select,
    output logic      [1:0]  high_side_switch_output,
    output logic             wake_filter_window,
    output logic             cyclic_wake_event
);
    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (TICK_CYC < 2 || TICK_CYC > 65536) begin : g_bad_tick
        $error("TICK_CYC must lie in 2 to 65536");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [15:0] setup_reg;          // periodic_timer_setup contents
    logic [15:0] tick_cnt_reg;       // Tick divider
    logic        tick_reg;           // One-cycle 1 us enable
    logic        wr_hit;             // Write to our address
    logic [2:0]  on_code  [2];       // Per-timer on-time codes
    logic [2:0]  per_code [2];       // Per-timer period codes
    logic [1:0]  run;                // Timer running
    logic [1:0]  hold_high;          // Stopped-high code
    logic [1:0]  t_drive;            // Drive level from each timer
    logic [1:0]  t_win;              // Filter window per timer
    logic [1:0]  t_end;              // End of on-time per timer
    dct_ticks_t  on_ticks  [2];
    dct_ticks_t  per_ticks [2];
    dct_wake_t   wake_sel;
    logic        filt_next;
    logic        wake_next;

    assign wr_hit = reg_wr && (reg_addr == `DCT_SETUP_ADDR);
    assign wake_sel = dct_wake_t'(setup_reg[`DCT_WAKE_LSB +: 2]);
    assign on_code[0]  = setup_reg[`DCT_T1_ON_LSB +: 3];   // R04
    assign per_code[0] = setup_reg[`DCT_T1_PER_LSB +: 3];  // R05
    assign on_code[1]  = setup_reg[`DCT_T2_ON_LSB +: 3];   // R01
    assign per_code[1] = setup_reg[`DCT_T2_PER_LSB +: 3];  // R03

    // ----------------------------------------------------------------
    // Code decoders
    // ----------------------------------------------------------------
    // On-time in ticks; stop codes give zero and are not run
    function automatic dct_ticks_t on_us(input logic [2:0] c);
        case (c)
            3'h1:    on_us = `DCT_ON_C1_US;
            3'h2:    on_us = `DCT_ON_C2_US;
            3'h3:    on_us = `DCT_ON_C3_US;
            3'h4:    on_us = `DCT_ON_C4_US;
            3'h5:    on_us = `DCT_ON_C5_US;
            default: on_us = '0;
        endcase
    endfunction

    // Period in ticks, eight steps
    function automatic dct_ticks_t per_us(input logic [2:0] c);
        case (c)
            3'h0:    per_us = `DCT_PER_C0_US;
            3'h1:    per_us = `DCT_PER_C1_US;
            3'h2:    per_us = `DCT_PER_C2_US;
            3'h3:    per_us = `DCT_PER_C3_US;
            3'h4:    per_us = `DCT_PER_C4_US;
            3'h5:    per_us = `DCT_PER_C5_US;
            3'h6:    per_us = `DCT_PER_C6_US;
            default: per_us = `DCT_PER_C7_US;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Tick divider
    // ----------------------------------------------------------------
    // Single clock; the timers advance on this enable only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == 16'(TICK_CYC - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
            tick_reg     <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Setup register
    // ----------------------------------------------------------------
    // Clears outrank per-timer clears, which outrank software writes.
    // Fault inputs other than restart never reach this register.
    always_ff @(posedge sys_clk) begin  // R11
        if (rst || soft_reset_req || restart_clear) begin
            setup_reg <= `DCT_SETUP_RESET;  // R08
        end else if (|sense_clear) begin
            // Hardware clear of a timer that was sensing a cleared switch
            if (sense_clear[0]) begin
                setup_reg[`DCT_T1_ON_LSB +: 3]  <= 3'h0;  // R10
                setup_reg[`DCT_T1_PER_LSB +: 3] <= 3'h0;  // R10
            end
            if (sense_clear[1]) begin
                setup_reg[`DCT_T2_ON_LSB +: 3]  <= 3'h0;  // R10
                setup_reg[`DCT_T2_PER_LSB +: 3] <= 3'h0;  // R10
            end
        end else if (wr_hit) begin
            // Reserved bits never store
            setup_reg <= reg_wdata & `DCT_SETUP_RWMASK;  // R07
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Returns live contents, so hardware clears are visible
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == `DCT_SETUP_ADDR) begin
                reg_rdata <= setup_reg & `DCT_SETUP_RWMASK;  // R15
            end else begin
                // Unmapped address reads zero
                reg_rdata <= 16'h0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        assign on_ticks[i]  = on_us(on_code[i]);
        assign per_ticks[i] = per_us(per_code[i]);
        // Runs only while owned by a switch and given a running code
        assign run[i] = timer_assigned[i] &&
                        (on_code[i] != 3'h0) && !on_code[i][2] ||
                        timer_assigned[i] && (on_code[i] == 3'h4) ||
                        timer_assigned[i] && (on_code[i] == 3'h5);  // R09
        // Code 111 behaves as 110
        assign hold_high[i] = on_code[i][2] && on_code[i][1];  // R02

        dct_cyc_timer u_tmr (
            .sys_clk   (sys_clk),
            .rst       (rst),
            .tick      (tick_reg),
            .run       (run[i]),
            .hold_high (hold_high[i]),
            .restart   (wr_hit),
            .on_ticks  (on_ticks[i]),
            .per_ticks (per_ticks[i]),
            .drive     (t_drive[i]),
            .filt_win  (t_win[i]),
            .on_end    (t_end[i])
        );
    end

    assign high_side_switch_output = t_drive;

    // ----------------------------------------------------------------
    // Wake filter strobe and cyclic wake
    // ----------------------------------------------------------------
    // Wake taps the same timer that drives sensing, so both coexist
    always_comb begin
        filt_next = 1'b0;
        wake_next = 1'b0;
        case (wake_filter_select)
            DCT_FILT_TIMER1: filt_next = t_win[0];  // R13
            DCT_FILT_TIMER2: filt_next = t_win[1];  // R13
            default:         filt_next = 1'b0;
        endcase
        case (wake_sel)
            DCT_WAKE_T1: wake_next = t_end[0];  // R06 R12
            DCT_WAKE_T2: wake_next = t_end[1];  // R06 R12
            // Disabled and reserved give no wake
            default:     wake_next = 1'b0;
        endcase
    end

    // Registered so every top output leaves a flip-flop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wake_filter_window <= 1'b0;
            cyclic_wake_event  <= 1'b0;
        end else begin
            wake_filter_window <= filt_next;
            cyclic_wake_event  <= wake_next;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_t2_on;
        (on_code[1] == 3'h5) |-> (on_ticks[1] == 21'h04e20);
    endproperty
    a_t2_on: assert property (p_t2_on)  // R01
        else $error("Timer 2 on-time decode wrong");

    property p_stop_low;
        (on_code[0] == 3'h0)[*2] |-> !high_side_switch_output[0];
    endproperty
    a_stop_low: assert property (p_stop_low)  // R02
        else $error("Stopped-low timer drives high");

    property p_stop_high;
        (on_code[1][2:1] == 2'b11)[*2] |-> high_side_switch_output[1];
    endproperty
    a_stop_high: assert property (p_stop_high)  // R02
        else $error("Stopped-high timer drives low");

    property p_per;
        (per_code[0] == 3'h7) |-> (per_ticks[0] == 21'h1e8480);
    endproperty
    a_per: assert property (p_per)  // R05
        else $error("Timer 1 period decode wrong");

    property p_rsvd;
        (setup_reg[12] == 1'b0) && (setup_reg[3] == 1'b0);
    endproperty
    a_rsvd: assert property (p_rsvd)  // R07
        else $error("Reserved bit set");

    property p_clear;
        (soft_reset_req || restart_clear) |=> (setup_reg == 16'h0000);
    endproperty
    a_clear: assert property (p_clear)  // R08
        else $error("Register not cleared");

    property p_unassigned;
        (!timer_assigned[0] && !on_code[0][2])[*2] |->
            !high_side_switch_output[0];
    endproperty
    a_unassigned: assert property (p_unassigned)  // R09
        else $error("Unassigned timer runs");

    property p_sense_clr;
        (sense_clear[1] && !soft_reset_req && !restart_clear) |=>
            (setup_reg[15:13] == 3'h0) && (setup_reg[11:9] == 3'h0);
    endproperty
    a_sense_clr: assert property (p_sense_clr)  // R10
        else $error("Timer 2 settings survive switch clear");

    property p_stable;
        !(wr_hit || |sense_clear || soft_reset_req || restart_clear)
            |=> $stable(setup_reg);
    endproperty
    a_stable: assert property (p_stable)  // R11
        else $error("Settings changed without cause");

    property p_wake;
        cyclic_wake_event |->
            $past(wake_sel == DCT_WAKE_T1 && t_end[0] ||
                  wake_sel == DCT_WAKE_T2 && t_end[1]);
    endproperty
    a_wake: assert property (p_wake)  // R06
        else $error("Wake from unselected timer");

    property p_filt;
        wake_filter_window |-> $past(
            wake_filter_select == 3'h2 && t_win[0] ||
            wake_filter_select == 3'h3 && t_win[1]);
    endproperty
    a_filt: assert property (p_filt)  // R13
        else $error("Filter window without timer");
endmodule

// file: sim/dct_far_model.sv
`timescale 1ns/10ps

// Switch loads and wake filter stand-in: assigns timers, measures pulses
module dct_far_model (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [1:0]  high_side_switch_output,
    input  wire logic        wake_filter_window,
    input  wire logic        cyclic_wake_event,
    input  wire logic [1:0]  own_req,          // Bench asks to own switches
    output logic      [1:0]  timer_assigned,
    output logic      [31:0] hi_len [2],       // Last on-time in cycles
    output logic      [31:0] per_len [2],      // Last rise-to-rise in cycles
    output logic      [31:0] win_len,          // Last filter window in cycles
    output logic      [31:0] wake_cnt          // Wake pulses seen
);
    // ------------------------------------------------------------
    // Measurement
    // ------------------------------------------------------------
    logic [1:0]  hs_d;                         // Previous output level
    logic        win_d;                        // Previous window level
    logic [31:0] hi_cnt [2];                   // Running on-time count
    logic [31:0] per_cnt [2];                  // Running period count
    logic [31:0] win_cnt;                      // Running window count

    // Switch is assigned whenever the bench raises own_req, with no delay
    assign timer_assigned = own_req;

    // Counts restart and hi_len clears at each rise, so a stale on-time never passes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hs_d     <= 2'h0;
            win_d    <= 1'h0;
            wake_cnt <= 32'h0;
            win_cnt  <= 32'h0;
            win_len  <= 32'h0;
            for (int i = 0; i < 2; i++) begin
                hi_cnt[i]  <= 32'h0;
                per_cnt[i] <= 32'h0;
                hi_len[i]  <= 32'h0;
                per_len[i] <= 32'h0;
            end
        end else begin
            hs_d  <= high_side_switch_output;
            win_d <= wake_filter_window;
            if (cyclic_wake_event) begin
                wake_cnt <= wake_cnt + 32'h1;
            end
            // Window: count high cycles, keep at fall
            if (wake_filter_window) begin
                win_cnt <= win_d ? win_cnt + 32'h1 : 32'h1;
            end else if (win_d) begin
                win_len <= win_cnt;
            end
            for (int i = 0; i < 2; i++) begin
                if (high_side_switch_output[i] && !hs_d[i]) begin
                    per_len[i] <= per_cnt[i];
                    per_cnt[i] <= 32'h1;
                    hi_cnt[i]  <= 32'h1;
                    hi_len[i]  <= 32'h0;
                end else begin
                    per_cnt[i] <= per_cnt[i] + 32'h1;
                    if (high_side_switch_output[i]) begin
                        hi_cnt[i] <= hi_cnt[i] + 32'h1;
                    end else if (hs_d[i]) begin
                        hi_len[i] <= hi_cnt[i];
                    end
                end
            end
        end
    end
endmodule

// file: sim/dct_timer_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "dct_params.svh"

module dct_timer_ctrl_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int TC    = 2;                  // Short tick keeps run brief
    localparam int LIMIT = 90000;              // Cycle ceiling for the run
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [6:0]  reg_addr = 7'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        soft_reset_req = 1'b0;
    logic        restart_clear = 1'b0;
    logic [1:0]  sense_clear = 2'h0;
    logic [1:0]  timer_assigned;
    logic [2:0]  wake_filter_select = 3'h0;
    logic [1:0]  high_side_switch_output;
    logic        wake_filter_window;
    logic        cyclic_wake_event;
    logic [1:0]  own_req = 2'h0;               // Switch ownership request
    logic [31:0] hi_len [2];
    logic [31:0] per_len [2];
    logic [31:0] win_len;
    logic [31:0] wake_cnt;
    logic [31:0] w0;                           // Wake count snapshot
    logic [15:0] d;                            // Read-back word
    logic [15:0] v;                            // Written word
    int          mismatches = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          seed = 21315;

`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end

    always #4 sys_clk = ~sys_clk;

    dct_timer_ctrl #(.TICK_CYC(TC)) dct_timer_ctrl_inst (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .soft_reset_req(soft_reset_req), .restart_clear(restart_clear),
        .sense_clear(sense_clear), .timer_assigned(timer_assigned),
        .wake_filter_select(wake_filter_select),
        .high_side_switch_output(high_side_switch_output),
        .wake_filter_window(wake_filter_window), .cyclic_wake_event(cyclic_wake_event));

    dct_far_model dct_far_model_inst (
        .sys_clk(sys_clk), .rst(rst), .high_side_switch_output(high_side_switch_output),
        .wake_filter_window(wake_filter_window), .cyclic_wake_event(cyclic_wake_event),
        .own_req(own_req), .timer_assigned(timer_assigned), .hi_len(hi_len),
        .per_len(per_len), .win_len(win_len), .wake_cnt(wake_cnt));

    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] cfg(input logic [2:0] t2on, input logic [2:0] t2per,
        input logic [1:0] wk, input logic [2:0] t1on, input logic [2:0] t1per);
        return {t2on, 1'b0, t2per, wk, t1on, 1'b0, t1per};
    endfunction

    // On-time in clock cycles for running codes 1..3
    function automatic logic [31:0] on_cyc(input int c);
        logic [31:0] t;
        t = (c == 1) ? 32'd100 : (c == 2) ? 32'd300 : 32'd1000;
        return t * TC;
    endfunction

    // First tick phase is free, so allow one tick of slack
    function automatic logic near(input logic [31:0] a, input logic [31:0] e);
        return (a + TC >= e) && (a <= e + TC);
    endfunction

    // ------------------------------------------------------------
    // Register port tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [15:0] x);
        @(posedge sys_clk);
        #1 reg_addr = a;
        reg_wdata = x;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] x);
        @(posedge sys_clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #1 reg_rd = 1'b0;
        x = reg_rdata;
    endtask

    // One-cycle pulse on {soft reset, restart, sense clears}
    task automatic clr(input logic [3:0] m);
        @(posedge sys_clk);
        #1 {soft_reset_req, restart_clear, sense_clear} = m;
        @(posedge sys_clk);
        #1 {soft_reset_req, restart_clear, sense_clear} = 4'h0;
    endtask

    task automatic conclude;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst = 1'b0;
        rd(7'h06, d);
        `CHK(d, `DCT_SETUP_RESET, "reset value")
        wr(7'h06, 16'hffff);
        rd(7'h06, d);
        `CHK(d, 16'heff7, "reserved bits")
        `CHK(high_side_switch_output, 2'b11, "code 111 high")
        wr(7'h06, cfg(3'b110, 3'h0, 2'h0, 3'b000, 3'h0));
        repeat (3) @(posedge sys_clk);
        #1 `CHK(high_side_switch_output, 2'b10, "code 110 high, 000 low")
        // Unmapped address is ignored and reads zero
        wr(7'h07, 16'h1234);
        rd(7'h06, d);
        `CHK(d, 16'hc000, "unmapped write")
        rd(7'h07, d);
        `CHK(d, 16'h0000, "unmapped read")
        // Running code without ownership leaves the switch low
        wr(7'h06, cfg(3'h1, 3'h0, 2'h0, 3'h1, 3'h0));
        repeat (50) @(posedge sys_clk);
        #1 `CHK(high_side_switch_output, 2'b00, "unassigned runs")
        own_req = 2'b11;
        for (int c = 1; c <= 5; c++) begin
            wr(7'h06, cfg(c[2:0], 3'h0, 2'h0, c[2:0], 3'h0));
            if (c <= 3) begin
                repeat (on_cyc(c) + 20) @(posedge sys_clk);
                #1 `CHK(near(hi_len[0], on_cyc(c)), 1'b1, "t1 on-time")
                `CHK(near(hi_len[1], on_cyc(c)), 1'b1, "t2 on-time")
            end else begin
                // Long codes: still on just past the 1 ms point
                repeat (2100) @(posedge sys_clk);
                #1 `CHK(high_side_switch_output, 2'b11, "long on-time")
            end
        end
        // Periods and wake from timer 1 with filter on timer 1
        wake_filter_select = 3'b010;
        wr(7'h06, 16'h0000);
        w0 = wake_cnt;
        wr(7'h06, cfg(3'h1, 3'h1, 2'b01, 3'h1, 3'h0));
        repeat (40100) @(posedge sys_clk);
        #1 `CHK(per_len[0], 32'd10000 * TC, "t1 period")
        `CHK(near(per_len[1], 32'd20000 * TC), 1'b1, "t2 period")
        `CHK(wake_cnt - w0, 32'd2, "t1 wake count")
        `CHK(win_len, 32'd16 * TC, "filter window")
        // Wake from timer 2, then reserved wake code
        wake_filter_select = 3'b011;
        w0 = wake_cnt;
        wr(7'h06, cfg(3'h1, 3'h0, 2'b10, 3'h2, 3'h0));
        repeat (400) @(posedge sys_clk);
        #1 `CHK(wake_cnt - w0, 32'd1, "t2 wake")
        `CHK(win_len, 32'd16 * TC, "t2 window")
        w0 = wake_cnt;
        wr(7'h06, cfg(3'h1, 3'h0, 2'b11, 3'h1, 3'h0));
        repeat (400) @(posedge sys_clk);
        #1 `CHK(wake_cnt - w0, 32'd0, "reserved wake")
        // Hardware clears are visible on read
        v = cfg(3'h3, 3'h5, 2'b01, 3'h2, 3'h6);
        wr(7'h06, v);
        clr(4'b0001);
        rd(7'h06, d);
        `CHK(d, v & 16'hff88, "t1 sense clear")
        clr(4'b0010);
        rd(7'h06, d);
        `CHK(d, v & 16'h0188, "t2 sense clear")
        clr(4'b0100);
        rd(7'h06, d);
        `CHK(d, 16'h0000, "restart clear")
        wr(7'h06, v);
        clr(4'b1000);
        rd(7'h06, d);
        `CHK(d, 16'h0000, "soft reset clear")
        // Random words read back with reserved bits zero
        repeat (6) begin
            v = 16'($random(seed));
            own_req = v[1:0];
            wr(7'h06, v);
            rd(7'h06, d);
            `CHK(d, v & `DCT_SETUP_RWMASK, "random read-back")
        end
        conclude();
    end
endmodule
